// ### logic/tcr_device.sv
// Tile configuration register bank: switch-side message port and the
// local processor status port. Assumes straps and the one-time memory
// word are stable at reset release.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module tcr_device (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Switch side
    tcr_link_if.dev LINK,
    // Local processor status port
    input wire logic [7:0] PS_ADDR,
    input wire logic PS_WRITE,
    input wire logic PS_READ,
    input wire logic [31:0] PS_WDATA,
    output logic [31:0] PS_RDATA,
    output logic PS_RVALID,
    // Boot straps and one-time memory word
    input wire logic [7:0] PROC_NUM,
    input wire logic [1:0] BOOT_CLK_STRAP,
    input wire logic BOOT_FROM_RAM,
    input wire logic BOOT_FROM_TEST,
    input wire logic BOOT_SEL_OVERRIDE,
    input wire logic CORE1_OFF,
    input wire logic SKIP_OTP_POLL,
    input wire logic [31:0] OTP_SEC_WORD,
    // Security controls
    output logic GLOBAL_DEBUG_BLOCK,
    output logic [3:0] OTP_SECTOR_LOCK,
    output logic REDUNDANT_ROWS_EN,
    output logic FORCE_OTP_BOOT,
    output logic TEST_PORT_CFG_BLOCK,
    output logic DEBUG_TAP_DISABLE
);
    import tcr_pkg::*;

    typedef struct packed {
        tcr_dev_st_t st;
        logic [3:0] cnt;
        logic [7:0] cmd;
        logic [63:0] rx;
        logic [63:0] tx;
        logic loaded;
        logic [31:0] boot;
        logic [31:0] sec;
        logic dbg_perm;
        logic [7:0][31:0] scratch;
        logic [31:0] ps_rdata;
        logic ps_rvalid;
    } tcr_dev_state_t;

    tcr_dev_state_t s;
    tcr_dev_state_t next_s;

    // ==========================================================
    // Next state
    always_comb begin
        logic [71:0] frame;
        logic is_wr;
        logic ok;
        logic last;
        logic [31:0] rd;
        logic [23:0] chan;
        logic [7:0] regn;
        logic [31:0] data;
        frame = '0;
        is_wr = 1'b0;
        ok = 1'b0;
        last = 1'b0;
        rd = '0;
        chan = '0;
        regn = '0;
        data = '0;
        next_s = s;
        next_s.ps_rvalid = 1'b0;
        // Straps and the security word are caught once, one edge after
        // reset release, so no port value enters the asynchronous reset.
        if (!s.loaded) begin
            next_s.loaded = 1'b1;
            next_s.sec = OTP_SEC_WORD & SEC_WR_MASK;
            next_s.boot = '0;
            next_s.boot[BOOT_PROC_LSB +: 8] = PROC_NUM;
            next_s.boot[BOOT_STRAP_LSB +: 2] = BOOT_CLK_STRAP;
            next_s.boot[BOOT_RAM_BIT] = BOOT_FROM_RAM;
            next_s.boot[BOOT_TEST_BIT] = BOOT_FROM_TEST;
            next_s.boot[BOOT_OVR_BIT] = BOOT_SEL_OVERRIDE;
            next_s.boot[BOOT_CORE1_OFF_BIT] = CORE1_OFF;
            next_s.boot[BOOT_SKIP_POLL_BIT] = SKIP_OTP_POLL;
        end
        // Processor status port: whole words only.
        if (PS_READ) begin
            next_s.ps_rvalid = 1'b1;
            if (PS_ADDR == REG_BOOT_STATUS) begin
                next_s.ps_rdata = s.boot;
            end else if (PS_ADDR == REG_SEC_LOCAL) begin
                next_s.ps_rdata = s.sec;
            end else if (PS_ADDR[7:3] == REG_SCRATCH_BASE[7:3]) begin
                next_s.ps_rdata = s.scratch[PS_ADDR[2:0]];
            end else begin
                next_s.ps_rdata = '0;
            end
        end
        if (PS_WRITE) begin
            if (PS_ADDR == REG_SEC_LOCAL && !s.sec[SEC_WLOCK_BIT]) begin
                next_s.sec = PS_WDATA & SEC_WR_MASK;
            end else if (PS_ADDR[7:3] == REG_SCRATCH_BASE[7:3]) begin
                next_s.scratch[PS_ADDR[2:0]] = PS_WDATA;
            end
        end
        // Switch-side messages.
        unique case (s.st)
            TCR_DEV_RX: begin
                if (LINK.req_valid) begin
                    frame = {s.rx, LINK.req_byte};
                    next_s.rx = frame[63:0];
                    next_s.cnt = s.cnt + 4'h1;
                    if (s.cnt == 4'h0) begin
                        next_s.cmd = LINK.req_byte;
                    end
                    is_wr = (s.cnt == 4'h0) ? (LINK.req_byte == CMD_WRITE)
                                            : (s.cmd == CMD_WRITE);
                    last = is_wr ? (s.cnt == REQ_WR_BYTES - 4'h1)
                                 : (s.cnt == REQ_RD_BYTES - 4'h1);
                end
                if (last) begin
                    if (is_wr) begin
                        chan = frame[63:40];
                        regn = frame[39:32];
                        data = frame[31:0];
                    end else begin
                        chan = frame[31:8];
                        regn = frame[7:0];
                    end
                    ok = 1'b1;
                    if (regn == REG_IDENT) begin
                        rd = {ID_PROC, ID_NODE, ID_REV, ID_VER};
                    end else if (regn == REG_DESC_ONE) begin
                        rd = {N_CHANEND, N_LOCK, N_SYNC, 8'h00};
                    end else if (regn == REG_DESC_TWO) begin
                        rd = {16'h0000, N_CLKBLK, N_TIMER};
                    end else if (regn == REG_DEBUG_PERM) begin
                        rd = {31'h0, s.dbg_perm};
                        if (is_wr) begin
                            next_s.dbg_perm = data[DBG_PERM_BIT];
                        end
                    end else if (regn == REG_SEC_MIRROR) begin
                        rd = s.sec;
                    end else if (regn[7:3] == REG_SCRATCH_BASE[7:3]) begin
                        rd = s.scratch[regn[2:0]];
                        if (is_wr && s.dbg_perm) begin
                            ok = 1'b0;
                        end else if (is_wr) begin
                            next_s.scratch[regn[2:0]] = data;
                        end
                    end else begin
                        ok = 1'b0;
                    end
                    next_s.cnt = 4'h0;
                    if (!(is_wr && chan[7:0] == NO_REPLY_MARK)) begin
                        next_s.st = TCR_DEV_TX;
                        next_s.tx = {chan, ok ? STAT_ACK : STAT_NACK,
                                     is_wr ? 32'h0 : rd};
                        next_s.cnt = is_wr ? RSP_WR_BYTES : RSP_RD_BYTES;
                    end
                end
            end
            TCR_DEV_TX: begin
                if (LINK.rsp_ready) begin
                    next_s.tx = {s.tx[55:0], 8'h00};
                    next_s.cnt = s.cnt - 4'h1;
                    if (s.cnt == 4'h1) begin
                        next_s.st = TCR_DEV_RX;
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign LINK.req_ready = (s.st == TCR_DEV_RX);
    assign LINK.rsp_valid = (s.st == TCR_DEV_TX);
    assign LINK.rsp_byte = s.tx[63:56];
    assign PS_RDATA = s.ps_rdata;
    assign PS_RVALID = s.ps_rvalid;
    assign GLOBAL_DEBUG_BLOCK = s.sec[SEC_GDBG_BIT];
    assign OTP_SECTOR_LOCK = s.sec[SEC_SECT_LSB +: 4]
                             | {4{s.sec[SEC_MLOCK_BIT]}};
    assign REDUNDANT_ROWS_EN = s.sec[SEC_RED_BIT];
    assign FORCE_OTP_BOOT = s.sec[SEC_FORCE_BIT];
    assign TEST_PORT_CFG_BLOCK = s.sec[SEC_TPCFG_BIT];
    assign DEBUG_TAP_DISABLE = s.sec[SEC_TAP_BIT];
endmodule : tcr_device
`default_nettype wire

// ### logic/tcr_pkg.sv
// Constants, types and message layout shared by both ends of the tile
// configuration register link. Assumes one 250 MHz clock on each end.
package tcr_pkg;
    // ==========================================================
    // Switch-side and processor-side register numbers
    localparam logic [7:0] REG_IDENT = 8'h00;
    localparam logic [7:0] REG_DESC_ONE = 8'h01;
    localparam logic [7:0] REG_DESC_TWO = 8'h02;
    localparam logic [7:0] REG_BOOT_STATUS = 8'h03;
    localparam logic [7:0] REG_DEBUG_PERM = 8'h04;
    localparam logic [7:0] REG_SEC_LOCAL = 8'h05;
    localparam logic [7:0] REG_SEC_MIRROR = 8'h07;
    localparam logic [7:0] REG_SCRATCH_BASE = 8'h20;
    localparam logic [7:0] PS_RID_TYPE = 8'h0B;
    localparam int PS_RID_SHIFT = 8;
    // ==========================================================
    // Field positions
    localparam int BOOT_PROC_LSB = 16;
    localparam int BOOT_OVR_BIT = 8;
    localparam int BOOT_CORE1_OFF_BIT = 5;
    localparam int BOOT_SKIP_POLL_BIT = 4;
    localparam int BOOT_RAM_BIT = 3;
    localparam int BOOT_TEST_BIT = 2;
    localparam int BOOT_STRAP_LSB = 0;
    localparam int SEC_WLOCK_BIT = 31;
    localparam int SEC_GDBG_BIT = 14;
    localparam int SEC_MLOCK_BIT = 12;
    localparam int SEC_SECT_LSB = 8;
    localparam int SEC_RED_BIT = 7;
    localparam int SEC_FORCE_BIT = 5;
    localparam int SEC_TPCFG_BIT = 4;
    localparam int SEC_TAP_BIT = 0;
    localparam logic [31:0] SEC_WR_MASK = 32'h80005FB1;
    localparam int DBG_PERM_BIT = 0;
    // ==========================================================
    // Identity and resource counts; identity values are arbitrary.
    localparam logic [7:0] ID_PROC = 8'h00;
    localparam logic [7:0] ID_NODE = 8'h00;
    localparam logic [7:0] ID_REV = 8'h01;
    localparam logic [7:0] ID_VER = 8'h01;
    localparam logic [7:0] N_CHANEND = 8'h20;
    localparam logic [7:0] N_LOCK = 8'h04;
    localparam logic [7:0] N_SYNC = 8'h07;
    localparam logic [7:0] N_CLKBLK = 8'h06;
    localparam logic [7:0] N_TIMER = 8'h0A;
    // ==========================================================
    // Message layout
    localparam logic [7:0] CMD_READ = 8'h01;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] STAT_ACK = 8'h00;
    localparam logic [7:0] STAT_NACK = 8'h01;
    localparam logic [7:0] NO_REPLY_MARK = 8'hFF;
    localparam logic [3:0] REQ_RD_BYTES = 4'h5;
    localparam logic [3:0] REQ_WR_BYTES = 4'h9;
    localparam logic [3:0] RSP_RD_BYTES = 4'h8;
    localparam logic [3:0] RSP_WR_BYTES = 4'h4;
    // ==========================================================
    // Requester register map on AXI4-Lite
    localparam logic [7:0] H_CTRL = 8'h00;
    localparam logic [7:0] H_CHAN = 8'h04;
    localparam logic [7:0] H_REGNUM = 8'h08;
    localparam logic [7:0] H_WDATA = 8'h0C;
    localparam logic [7:0] H_STATUS = 8'h10;
    localparam logic [7:0] H_RDATA = 8'h14;
    localparam logic [7:0] H_RID = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // State machines
    typedef enum logic {TCR_DEV_RX, TCR_DEV_TX} tcr_dev_st_t;
    typedef enum logic [1:0] {TCR_H_IDLE, TCR_H_SEND, TCR_H_RECV} tcr_host_st_t;
endpackage : tcr_pkg

// ### logic/tcr_link_if.sv
// Byte link between a requester and the tile register bank.
// Each direction moves one byte when valid and ready are both high.
`timescale 1ns/1ns
`default_nettype none
interface tcr_link_if;
    logic req_valid;
    logic req_ready;
    logic [7:0] req_byte;
    logic rsp_valid;
    logic rsp_ready;
    logic [7:0] rsp_byte;
    modport dev (input req_valid, input req_byte, output req_ready,
                 output rsp_valid, output rsp_byte, input rsp_ready);
    modport req (output req_valid, output req_byte, input req_ready,
                 input rsp_valid, input rsp_byte, output rsp_ready);
endinterface : tcr_link_if
`default_nettype wire

// ### logic/tcr_requester.sv
// Remote requester: software sets up one register access over
// AXI4-Lite and the block sends it over the byte link to the bank.
// Assumes one transfer at a time; a start while busy is dropped.
`timescale 1ns/1ns
`default_nettype none
module tcr_requester (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RSTN,
    // AXI4-Lite slave
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Link to the bank
    tcr_link_if.req LINK
);
    import tcr_pkg::*;

    typedef struct packed {
        tcr_host_st_t st;
        logic [3:0] cnt;
        logic [71:0] txb;
        logic [55:0] rxb;
        logic quiet;
        logic wr_op;
        logic [23:0] chan;
        logic [7:0] regnum;
        logic [31:0] wdata;
        logic done;
        logic [7:0] status;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wd;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] axi_rdata;
    } tcr_host_state_t;

    tcr_host_state_t s;
    tcr_host_state_t next_s;

    // ==========================================================
    // Next state
    always_comb begin
        logic aw_now;
        logic w_now;
        logic [7:0] addr;
        logic [31:0] wv;
        logic [63:0] full;
        logic [31:0] rid;
        aw_now = s.aw_got | (AWVALID & AWREADY);
        w_now = s.w_got | (WVALID & WREADY);
        addr = s.aw_got ? s.awaddr : AWADDR;
        wv = s.w_got ? s.wd : WDATA;
        full = {s.rxb, LINK.rsp_byte};
        rid = ({24'h0, s.regnum} << PS_RID_SHIFT) | {24'h0, PS_RID_TYPE};
        next_s = s;
        if (AWVALID && AWREADY) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = AWADDR;
        end
        if (WVALID && WREADY) begin
            next_s.w_got = 1'b1;
            next_s.wd = WDATA;
        end
        if (s.bvalid && BREADY) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && RREADY) begin
            next_s.rvalid = 1'b0;
        end
        // Full-word writes only; byte strobes are ignored.
        if (aw_now && w_now && !s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            if (addr == H_CTRL) begin
                if (wv[0] && s.st == TCR_H_IDLE) begin
                    next_s.done = 1'b0;
                    next_s.wr_op = wv[1];
                    next_s.quiet = wv[1] && s.chan[7:0] == NO_REPLY_MARK;
                    next_s.txb = {wv[1] ? CMD_WRITE : CMD_READ, s.chan,
                                  s.regnum, wv[1] ? s.wdata : 32'h0};
                    next_s.cnt = wv[1] ? REQ_WR_BYTES : REQ_RD_BYTES;
                    next_s.st = TCR_H_SEND;
                end
            end else if (addr == H_CHAN) begin
                next_s.chan = wv[23:0];
            end else if (addr == H_REGNUM) begin
                next_s.regnum = wv[7:0];
            end else if (addr == H_WDATA) begin
                next_s.wdata = wv;
            end else if (addr != H_STATUS && addr != H_RDATA
                         && addr != H_RID) begin
                next_s.bresp = RESP_SLVERR;
            end
        end
        if (ARVALID && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OKAY;
            unique case (ARADDR)
                H_CTRL: next_s.axi_rdata = {30'h0, s.wr_op, 1'b0};
                H_CHAN: next_s.axi_rdata = {8'h00, s.chan};
                H_REGNUM: next_s.axi_rdata = {24'h0, s.regnum};
                H_WDATA: next_s.axi_rdata = s.wdata;
                H_STATUS: next_s.axi_rdata = {16'h0, s.status, 6'h00,
                                              s.done, s.st != TCR_H_IDLE};
                H_RDATA: next_s.axi_rdata = s.rdata;
                H_RID: next_s.axi_rdata = rid;
                default: begin
                    next_s.axi_rdata = '0;
                    next_s.rresp = RESP_SLVERR;
                end
            endcase
        end
        // Link side.
        unique case (s.st)
            TCR_H_IDLE: begin
            end
            TCR_H_SEND: begin
                if (LINK.req_ready) begin
                    next_s.txb = {s.txb[63:0], 8'h00};
                    next_s.cnt = s.cnt - 4'h1;
                    if (s.cnt == 4'h1) begin
                        next_s.rxb = '0;
                        next_s.cnt = s.wr_op ? RSP_WR_BYTES : RSP_RD_BYTES;
                        next_s.st = TCR_H_RECV;
                        if (s.quiet) begin
                            next_s.st = TCR_H_IDLE;
                            next_s.done = 1'b1;
                            next_s.status = STAT_ACK;
                        end
                    end
                end
            end
            TCR_H_RECV: begin
                if (LINK.rsp_valid) begin
                    next_s.rxb = full[55:0];
                    next_s.cnt = s.cnt - 4'h1;
                    if (s.cnt == 4'h1) begin
                        next_s.st = TCR_H_IDLE;
                        next_s.done = 1'b1;
                        next_s.status = s.wr_op ? full[7:0] : full[39:32];
                        if (!s.wr_op) begin
                            next_s.rdata = full[31:0];
                        end
                    end
                end
            end
            default: next_s.st = TCR_H_IDLE;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign AWREADY = !s.aw_got && !s.bvalid;
    assign WREADY = !s.w_got && !s.bvalid;
    assign BVALID = s.bvalid;
    assign BRESP = s.bresp;
    assign ARREADY = !s.rvalid;
    assign RVALID = s.rvalid;
    assign RRESP = s.rresp;
    assign RDATA = s.axi_rdata;
    assign LINK.req_valid = (s.st == TCR_H_SEND);
    assign LINK.req_byte = s.txb[71:64];
    assign LINK.rsp_ready = (s.st == TCR_H_RECV);
endmodule : tcr_requester
`default_nettype wire

// ### tb/tcr_link_properties.sv
// Protocol checker for the byte link between requester and register bank.
// Assumes both ends share REF_CLK and RSTN; instantiated beside the link.
`timescale 1ns/1ns
`default_nettype none
module tcr_link_properties (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Link signals
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [7:0] req_byte,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [7:0] rsp_byte
);
    import tcr_pkg::*;
    // ==========================================================
    // Message tracking
    logic [3:0] rq_cnt;
    logic [3:0] rs_cnt;
    logic [7:0] cmd;
    logic [7:0] chan_hi;
    logic [7:0] chan_lo;
    logic take;
    logic last;
    logic quiet;
    assign take = req_valid && req_ready;
    assign last = take && rq_cnt == ((cmd == CMD_WRITE) ?
                  REQ_WR_BYTES - 4'h1 : REQ_RD_BYTES - 4'h1);
    assign quiet = cmd == CMD_WRITE && chan_lo == NO_REPLY_MARK;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rq_cnt <= 4'h0;
            rs_cnt <= 4'h0;
            cmd <= 8'h00;
            chan_hi <= 8'h00;
            chan_lo <= 8'h00;
        end else begin
            if (take) rq_cnt <= last ? 4'h0 : rq_cnt + 4'h1;
            if (take && rq_cnt == 4'h0) cmd <= req_byte;
            if (take && rq_cnt == 4'h1) chan_hi <= req_byte;
            if (take && rq_cnt == 4'h3) chan_lo <= req_byte;
            if (last) rs_cnt <= 4'h0;
            else if (rsp_valid && rsp_ready) rs_cnt <= rs_cnt + 4'h1;
        end
    end
    // ==========================================================
    // Assertions
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    sequence s_quiet_end;
        last && quiet;
    endsequence
    sequence s_reply_start;
        ##1 rsp_valid && rsp_byte == chan_hi;
    endsequence
    a_reply_first: assert property (last && !quiet |-> s_reply_start)
        else $error("reply missing or wrong channel byte");
    a_quiet_write: assert property (s_quiet_end |=> !rsp_valid [*4])
        else $error("reply sent for quiet write");
    a_req_hold: assert property (req_valid && !req_ready |=>
        req_valid && $stable(req_byte)) else $error("request byte dropped");
    a_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
        rsp_valid && $stable(rsp_byte)) else $error("reply byte dropped");
    a_reply_len: assert property ($fell(rsp_valid) |-> rs_cnt ==
        ((cmd == CMD_WRITE) ? RSP_WR_BYTES : RSP_RD_BYTES))
        else $error("reply length wrong");
    a_bank_deaf: assert property (rsp_valid |-> !req_ready)
        else $error("bank accepts bytes while replying");
    a_one_msg: assert property (req_valid |-> !rsp_ready)
        else $error("request offered while awaiting reply");
    a_reply_ends: assert property ($rose(rsp_valid) |->
        ##[4:8] !rsp_valid) else $error("reply too long");
endmodule : tcr_link_properties
`default_nettype wire

// ### tb/tile_config_registers_bench.sv
// Bench for the tile register bank driven by the requester over AXI4-Lite.
// Assumes both design ends meet through tcr_link_if on one clock.
`timescale 1ns/1ns
`default_nettype none
module tile_config_registers_bench;
    import tcr_pkg::*;
    // ==========================================================
    // Signals
    logic ref_clk;
    logic rstn = 1'h0;
    logic [7:0] ps_addr = '0, awaddr = '0, araddr = '0, proc_num = 8'h5A;
    logic ps_write = '0, ps_read = '0, awvalid = '0, wvalid = '0;
    logic bready = '0, arvalid = '0, rready = '0;
    logic [6:0] pins = 7'h57;
    logic [31:0] ps_wdata = '0, wdata = '0, otp = 32'h7FFFFFFF;
    logic [31:0] ps_rdata, rdata;
    logic ps_rvalid, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [8:0] sec;
    int miscompares = 0;
    int checks_done = 0;
    tcr_link_if u_tcr_link_if ();
    tcr_device u_tcr_device (.REF_CLK(ref_clk), .RSTN(rstn),
        .LINK(u_tcr_link_if), .PS_ADDR(ps_addr), .PS_WRITE(ps_write),
        .PS_READ(ps_read), .PS_WDATA(ps_wdata), .PS_RDATA(ps_rdata),
        .PS_RVALID(ps_rvalid), .PROC_NUM(proc_num),
        .BOOT_CLK_STRAP(pins[6:5]), .BOOT_FROM_RAM(pins[4]),
        .BOOT_FROM_TEST(pins[3]), .BOOT_SEL_OVERRIDE(pins[2]),
        .CORE1_OFF(pins[1]), .SKIP_OTP_POLL(pins[0]), .OTP_SEC_WORD(otp),
        .GLOBAL_DEBUG_BLOCK(sec[8]), .OTP_SECTOR_LOCK(sec[7:4]),
        .REDUNDANT_ROWS_EN(sec[3]), .FORCE_OTP_BOOT(sec[2]),
        .TEST_PORT_CFG_BLOCK(sec[1]), .DEBUG_TAP_DISABLE(sec[0]));
    tcr_requester u_tcr_requester (.REF_CLK(ref_clk), .RSTN(rstn),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .LINK(u_tcr_link_if));
    tcr_link_properties u_tcr_link_properties (.REF_CLK(ref_clk),
        .RSTN(rstn), .req_valid(u_tcr_link_if.req_valid),
        .req_ready(u_tcr_link_if.req_ready),
        .req_byte(u_tcr_link_if.req_byte),
        .rsp_valid(u_tcr_link_if.rsp_valid),
        .rsp_ready(u_tcr_link_if.rsp_ready),
        .rsp_byte(u_tcr_link_if.rsp_byte));
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ps(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
        @(posedge ref_clk);
        ps_addr <= a;
        ps_write <= w;
        ps_read <= !w;
        ps_wdata <= d;
        @(posedge ref_clk);
        ps_write <= 1'h0;
        ps_read <= 1'h0;
        @(negedge ref_clk);
    endtask : ps
    task automatic ps_chk(input logic [7:0] a, input logic [31:0] e);
        ps(a, 1'h0, 32'h0);
        chk({31'h0, ps_rvalid}, 32'h1);
        chk(ps_rdata, e);
    endtask : ps_chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge ref_clk);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge ref_clk); while (!rvalid);
        rready <= 1'h0;
        d = rdata;
        r = rresp;
    endtask : axi_rd
    // Polls status until done; the watchdog bounds a hung link.
    task automatic link_op(input logic [7:0] rn, input logic w,
        input logic [31:0] d, input logic [23:0] ch, input logic [31:0] es);
        logic [31:0] st;
        logic [1:0] r;
        axi_wr(H_CHAN, {8'h00, ch});
        axi_wr(H_REGNUM, {24'h0, rn});
        axi_wr(H_WDATA, d);
        axi_wr(H_CTRL, {30'h0, w, 1'h1});
        do axi_rd(H_STATUS, st, r); while (st[1] !== 1'h1);
        chk(st, es);
    endtask : link_op
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    // ==========================================================
    // Clock, watchdog and tests
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        $display("FAIL %0t watchdog expired", $time);
        wrap_up();
    end
    initial begin
        logic [31:0] v;
        logic [1:0] r;
        logic [7:0] rn [4] = '{REG_IDENT, REG_DESC_ONE, REG_DESC_TWO,
                               REG_SEC_MIRROR};
        logic [31:0] ev [4] = '{{ID_PROC, ID_NODE, ID_REV, ID_VER},
            {N_CHANEND, N_LOCK, N_SYNC, 8'h00},
            {16'h0000, N_CLKBLK, N_TIMER}, 32'h80000000};
        repeat (4) @(posedge ref_clk);
        rstn <= 1'h1;
        repeat (2) @(posedge ref_clk);
        ps_chk(REG_BOOT_STATUS, 32'h005A013A);
        ps_chk(REG_SEC_LOCAL, 32'h00005FB1);
        chk({23'h0, sec}, 32'h000001FF);
        ps(REG_SEC_LOCAL, 1'h1, 32'h80000000);
        ps(REG_SEC_LOCAL, 1'h1, 32'hFFFFFFFF);
        ps_chk(REG_SEC_LOCAL, 32'h80000000);
        chk({23'h0, sec}, 32'h0);
        link_op(REG_SEC_MIRROR, 1'h1, 32'h0, 24'h123456, 32'h2);
        for (int i = 0; i < 4; i++) begin
            link_op(rn[i], 1'h0, 32'h0, 24'h123456, 32'h2);
            axi_rd(H_RDATA, v, r);
            chk(v, ev[i]);
        end
        link_op(REG_SCRATCH_BASE, 1'h1, 32'h12345678, 24'hABCDEF, 32'h2);
        ps_chk(REG_SCRATCH_BASE, 32'h12345678);
        link_op(8'h21, 1'h1, 32'hCAFEF00D, 24'h1234FF, 32'h2);
        ps_chk(8'h21, 32'hCAFEF00D);
        link_op(REG_DEBUG_PERM, 1'h1, 32'h1, 24'h123456, 32'h2);
        link_op(REG_SCRATCH_BASE, 1'h1, 32'h0, 24'h123456, 32'h102);
        ps_chk(REG_SCRATCH_BASE, 32'h12345678);
        axi_rd(H_RID, v, r);
        chk(v, 32'h0000200B);
        axi_rd(8'h40, v, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wrap_up();
    end
endmodule : tile_config_registers_bench
`default_nettype wire
